// File: hw/stl_ctrl.sv
/*
  cache controller that drives an asynchronous set-associative tag buffer,
  a data buffer and main memory on behalf of a local processor.
  assumes inputs are synchronous to clk, memory returns one word per
  mem_ack pulse, and the data buffer reads combinationally.
*/
// Operation
// - drive select low on miss for replacement
// - write hit writes data buffer chosen way
// - ignore uncached cycles, no contention
// - hold acknowledge until missed word present
// - write missing tag at allocated way
// - write miss fetches whole line first
// - write-through: memory written with cache
`default_nettype none
module stl_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // processor side
  input wire logic cpu_req,
  input wire stl_pkg::stl_cpu_req_t cpu_in,
  output logic cpu_ack,
  output logic [stl_pkg::DATA_W-1:0] cpu_rdata,
  // maintenance requests
  input wire logic maint_req,
  input wire stl_pkg::stl_maint_t maint_in,
  output logic maint_done,
  // tag buffer pins
  output stl_pkg::stl_tag_pins_t tag_pins,
  input wire stl_pkg::stl_tag_resp_t tag_resp,
  // data buffer
  output stl_pkg::stl_dbuf_t dbuf,
  input wire logic [stl_pkg::DATA_W-1:0] dbuf_rdata,
  // main memory
  output stl_pkg::stl_mem_req_t mem,
  input wire logic mem_ack,
  input wire logic [stl_pkg::DATA_W-1:0] mem_rdata
);

  typedef struct packed {
    stl_pkg::stl_state_t st;
    stl_pkg::stl_tag_pins_t pins;
    stl_pkg::stl_cpu_req_t req;
    logic [stl_pkg::WAY_W-1:0] way;
    logic [stl_pkg::WORD_W-1:0] beat;
    logic [stl_pkg::DATA_W-1:0] rdata;
    logic ack;
    logic done;
    stl_pkg::stl_mem_req_t mem;
    stl_pkg::stl_dbuf_t dbuf;
  } stl_ctrl_state_t;

  stl_ctrl_state_t s_reg;
  stl_ctrl_state_t s_next;
  logic tmr_load;
  logic [stl_pkg::TMR_W-1:0] tmr_len;
  logic tmr_expired;
  logic [stl_pkg::INDEX_W-1:0] req_index;
  logic [stl_pkg::WORD_W-1:0] req_word;
  logic settle;

  localparam logic [stl_pkg::TMR_W-1:0] LOOK_LEN = stl_pkg::TMR_W'(stl_pkg::LOOKUP_CYC);
  localparam logic [stl_pkg::TMR_W-1:0] STB_LEN = stl_pkg::TMR_W'(stl_pkg::STROBE_CYC);

  assign req_index = s_reg.req.addr[stl_pkg::INDEX_LSB +: stl_pkg::INDEX_W];
  assign req_word = s_reg.req.addr[stl_pkg::WORD_LSB +: stl_pkg::WORD_W];
  // requesters drop on the edge that sees the answer, so skip that one cycle
  assign settle = s_reg.ack || s_reg.done;

  stl_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .len(tmr_len),
    .expired(tmr_expired)
  );

  // sequencer; the tag buffer has no clock, so every strobe is held by the timer
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.done = 1'b0;
    s_next.dbuf.we = 1'b0;
    tmr_load = 1'b0;
    tmr_len = LOOK_LEN;
    case (s_reg.st)
      stl_pkg::ST_IDLE:
      begin
        if (maint_req && !settle)
        begin
          s_next.req.addr = maint_in.addr;
          s_next.pins.index = maint_in.addr[stl_pkg::INDEX_LSB +: stl_pkg::INDEX_W];
          s_next.pins.tag_bits = maint_in.addr[stl_pkg::TAG_LSB +: stl_pkg::TAG_W];
          s_next.pins.way_pick_bits = maint_in.way;
          s_next.pins.pick_explicit = maint_in.explicit;
          tmr_load = 1'b1;
          if (maint_in.op == stl_pkg::OP_FLUSH)
          begin
            s_next.pins.flush_n = 1'b0;
            tmr_len = STB_LEN;
            s_next.st = stl_pkg::ST_FLUSH;
          end
          else if (maint_in.explicit)
          begin
            s_next.pins.inval_n = 1'b0;
            s_next.pins.commit_n = 1'b0;
            tmr_len = STB_LEN;
            s_next.st = stl_pkg::ST_INV_COMMIT;
          end
          else
          begin
            s_next.pins.inval_n = 1'b0;
            s_next.st = stl_pkg::ST_INV_LOOK;
          end
        end
        else if (cpu_req && cpu_in.cacheable && !settle) // uncached cycles never leave idle
        begin
          s_next.req = cpu_in;
          s_next.pins.index = cpu_in.addr[stl_pkg::INDEX_LSB +: stl_pkg::INDEX_W];
          s_next.pins.tag_bits = cpu_in.addr[stl_pkg::TAG_LSB +: stl_pkg::TAG_W];
          s_next.pins.hit_repl_sel = 1'b1;
          tmr_load = 1'b1;
          s_next.st = stl_pkg::ST_LOOK;
        end
      end
      stl_pkg::ST_LOOK:
      begin
        if (tmr_expired)
        begin
          tmr_load = 1'b1;
          if (!tag_resp.match_n)
          begin
            // update-mode access: commit so the way turns youngest
            s_next.way = tag_resp.way_select_out;
            s_next.dbuf.way = tag_resp.way_select_out;
            s_next.dbuf.addr = {req_index, req_word};
            s_next.pins.commit_n = 1'b0;
            tmr_len = STB_LEN;
            s_next.st = stl_pkg::ST_HIT_COMMIT;
          end
          else
          begin
            s_next.pins.hit_repl_sel = 1'b0; // ask for the replacement way
            s_next.st = stl_pkg::ST_REP;
          end
        end
      end
      stl_pkg::ST_HIT_COMMIT:
      begin
        if (tmr_expired)
        begin
          s_next.pins.commit_n = 1'b1;
          s_next.st = s_reg.req.we ? stl_pkg::ST_WR_WORD : stl_pkg::ST_RD_DATA;
          if (s_reg.req.we)
          begin
            s_next.dbuf.we = 1'b1; // way from the tag buffer picks the element
            s_next.dbuf.wdata = s_reg.req.wdata;
            s_next.mem = '{req: 1'b1, we: 1'b1, addr: s_reg.req.addr, wdata: s_reg.req.wdata};
          end
        end
      end
      stl_pkg::ST_RD_DATA:
      begin
        s_next.rdata = dbuf_rdata;
        s_next.ack = 1'b1;
        s_next.st = stl_pkg::ST_IDLE;
      end
      stl_pkg::ST_WR_WORD:
      begin
        s_next.st = stl_pkg::ST_WR_MEM;
        if (mem_ack)
        begin
          s_next.mem.req = 1'b0;
          s_next.ack = 1'b1;
          s_next.st = stl_pkg::ST_IDLE;
        end
      end
      stl_pkg::ST_WR_MEM:
      begin
        // processor waits for the memory copy, keeping both copies equal
        if (mem_ack)
        begin
          s_next.mem.req = 1'b0;
          s_next.ack = 1'b1;
          s_next.st = stl_pkg::ST_IDLE;
        end
      end
      stl_pkg::ST_REP:
      begin
        if (tmr_expired)
        begin
          s_next.way = tag_resp.way_select_out;
          s_next.dbuf.way = tag_resp.way_select_out;
          s_next.beat = '0;
          s_next.mem = '{req: 1'b1, we: 1'b0, addr: {s_reg.req.addr[stl_pkg::ADDR_W-1:stl_pkg::INDEX_LSB],
            stl_pkg::WORD_W'(0), 2'h0}, wdata: '0};
          s_next.st = stl_pkg::ST_FETCH;
        end
      end
      stl_pkg::ST_FETCH:
      begin
        // whole line is fetched, also on a write miss
        if (mem_ack)
        begin
          s_next.dbuf.we = 1'b1;
          s_next.dbuf.addr = {req_index, s_reg.beat};
          s_next.dbuf.wdata = mem_rdata;
          if (s_reg.beat == req_word)
          begin
            s_next.rdata = mem_rdata;
          end
          if (s_reg.beat == stl_pkg::BEAT_LAST)
          begin
            s_next.mem.req = 1'b0;
            s_next.pins.write_n = 1'b0; // tag goes into the replacement way
            s_next.pins.commit_n = 1'b0;
            tmr_load = 1'b1;
            tmr_len = STB_LEN;
            s_next.st = stl_pkg::ST_TAG_WR;
          end
          else
          begin
            s_next.beat = s_reg.beat + 1'b1;
            s_next.mem.addr[stl_pkg::WORD_LSB +: stl_pkg::WORD_W] = s_reg.beat + 1'b1;
          end
        end
      end
      stl_pkg::ST_TAG_WR:
      begin
        if (tmr_expired)
        begin
          s_next.pins.write_n = 1'b1;
          s_next.pins.commit_n = 1'b1;
          s_next.pins.hit_repl_sel = 1'b1;
          if (s_reg.req.we)
          begin
            s_next.dbuf.we = 1'b1;
            s_next.dbuf.addr = {req_index, req_word};
            s_next.dbuf.wdata = s_reg.req.wdata;
            s_next.mem = '{req: 1'b1, we: 1'b1, addr: s_reg.req.addr, wdata: s_reg.req.wdata};
            s_next.st = stl_pkg::ST_WR_WORD;
          end
          else
          begin
            s_next.ack = 1'b1; // line and word are in place only now
            s_next.st = stl_pkg::ST_IDLE;
          end
        end
      end
      stl_pkg::ST_FLUSH:
      begin
        if (tmr_expired)
        begin
          s_next.pins.flush_n = 1'b1;
          s_next.done = 1'b1;
          s_next.st = stl_pkg::ST_IDLE;
        end
      end
      stl_pkg::ST_INV_LOOK:
      begin
        // implicit invalidation commits only on a match
        if (tmr_expired)
        begin
          if (!tag_resp.match_n)
          begin
            s_next.pins.commit_n = 1'b0;
            tmr_load = 1'b1;
            tmr_len = STB_LEN;
            s_next.st = stl_pkg::ST_INV_COMMIT;
          end
          else
          begin
            s_next.pins.inval_n = 1'b1;
            s_next.done = 1'b1;
            s_next.st = stl_pkg::ST_IDLE;
          end
        end
      end
      stl_pkg::ST_INV_COMMIT:
      begin
        if (tmr_expired)
        begin
          s_next.pins.commit_n = 1'b1;
          s_next.pins.inval_n = 1'b1;
          s_next.pins.pick_explicit = 1'b0;
          s_next.done = 1'b1;
          s_next.st = stl_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_next.st = stl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_reg <= '{st: stl_pkg::ST_IDLE, pins: stl_pkg::PINS_IDLE, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign tag_pins = s_reg.pins;
  assign cpu_ack = s_reg.ack;
  assign cpu_rdata = s_reg.rdata;
  assign maint_done = s_reg.done;
  assign mem = s_reg.mem;
  assign dbuf = s_reg.dbuf;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_miss_sel_low;
    (s_reg.st == stl_pkg::ST_LOOK && tmr_expired && tag_resp.match_n) |=> !tag_pins.hit_repl_sel [*2];
  endproperty
  a_miss_sel_low: assert property (p_miss_sel_low) else $error("select not low after miss");

  property p_write_hit_dbuf;
    (s_reg.st == stl_pkg::ST_HIT_COMMIT && tmr_expired && s_reg.req.we)
      |=> (dbuf.we && dbuf.way == $past(s_reg.way) && dbuf.wdata == $past(s_reg.req.wdata));
  endproperty
  a_write_hit_dbuf: assert property (p_write_hit_dbuf) else $error("write hit missed data buffer");

  property p_bypass_idle;
    (s_reg.st == stl_pkg::ST_IDLE && cpu_req && !cpu_in.cacheable && !maint_req)
      |=> (s_reg.st == stl_pkg::ST_IDLE && !mem.req && !cpu_ack && !dbuf.we);
  endproperty
  a_bypass_idle: assert property (p_bypass_idle) else $error("controller active on uncached cycle");

  property p_no_ack_in_fetch;
    (s_reg.st == stl_pkg::ST_FETCH || s_reg.st == stl_pkg::ST_REP) |-> !cpu_ack;
  endproperty
  a_no_ack_in_fetch: assert property (p_no_ack_in_fetch) else $error("ack during line fetch");

  property p_tag_write;
    $fell(tag_pins.write_n) |-> (!tag_pins.hit_repl_sel && !tag_pins.commit_n && $past(s_reg.st) == stl_pkg::ST_FETCH);
  endproperty
  a_tag_write: assert property (p_tag_write) else $error("tag write not at replacement way");

  property p_full_line;
    (s_reg.st == stl_pkg::ST_FETCH && mem_ack && s_reg.beat == stl_pkg::BEAT_LAST)
      |=> (s_reg.st == stl_pkg::ST_TAG_WR && !tag_pins.write_n);
  endproperty
  a_full_line: assert property (p_full_line) else $error("line fetch not completed before tag write");

  property p_write_through;
    (dbuf.we && s_reg.st == stl_pkg::ST_WR_WORD) |-> (mem.req && mem.we && mem.wdata == dbuf.wdata);
  endproperty
  a_write_through: assert property (p_write_through) else $error("memory not written with cache");

  property p_implicit_nomatch;
    (s_reg.st == stl_pkg::ST_INV_LOOK && tmr_expired && tag_resp.match_n) |=> (tag_pins.commit_n && maint_done);
  endproperty
  a_implicit_nomatch: assert property (p_implicit_nomatch) else $error("commit on unmatched invalidation");

  c_read_hit: cover property (s_reg.st == stl_pkg::ST_RD_DATA ##1 cpu_ack);
  c_read_miss: cover property (s_reg.st == stl_pkg::ST_TAG_WR && !s_reg.req.we ##[1:8] cpu_ack);
  c_write_miss: cover property (s_reg.st == stl_pkg::ST_TAG_WR && s_reg.req.we ##[1:8] s_reg.st == stl_pkg::ST_WR_WORD);
  c_flush: cover property (s_reg.st == stl_pkg::ST_FLUSH ##[1:8] maint_done);

endmodule
`default_nettype wire

// File: hw/stl_pkg.sv
/*
  shared constants and carrier types for the tag-buffer cache controller.
  assumes a 40 mhz system clock and an external asynchronous tag buffer
  whose pins are driven from flip-flops of the controller.
*/
`default_nettype none
package stl_pkg;

  // clock rate and tag buffer timing
  localparam int CLK_MHZ = 40;
  localparam int LOOKUP_NS = 45;  // address to match settle time
  localparam int STROBE_NS = 30;  // least width of commit, write, flush strobes
  localparam int LOOKUP_CYC = (LOOKUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 4;

  // processor address fields
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int WORD_LSB = 2;
  localparam int WORD_W = 2;
  localparam int INDEX_LSB = 4;
  localparam int INDEX_W = 8;
  localparam int TAG_LSB = 12;
  localparam int TAG_W = 20;
  localparam int WAY_W = 2;
  localparam int DBUF_AW = INDEX_W + WORD_W;
  localparam logic [WORD_W-1:0] BEAT_LAST = 2'h3;

  // maintenance operations
  localparam logic OP_FLUSH = 1'b0;
  localparam logic OP_INVAL = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE, ST_LOOK, ST_HIT_COMMIT, ST_RD_DATA, ST_WR_WORD, ST_WR_MEM,
    ST_REP, ST_FETCH, ST_TAG_WR, ST_FLUSH, ST_INV_LOOK, ST_INV_COMMIT
  } stl_state_t;

  // pins driven into the tag buffer
  typedef struct packed {
    logic [INDEX_W-1:0] index;
    logic [TAG_W-1:0] tag_bits;
    logic hit_repl_sel;       // high: lookup, low: replacement way
    logic commit_n;
    logic write_n;
    logic flush_n;
    logic inval_n;
    logic pick_explicit;      // high: invalidate the way on way_pick_bits
    logic [WAY_W-1:0] way_pick_bits;
  } stl_tag_pins_t;

  // pins read back from the tag buffer
  typedef struct packed {
    logic match_n;
    logic [WAY_W-1:0] way_select_out;
  } stl_tag_resp_t;

  typedef struct packed {
    logic we;
    logic cacheable;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } stl_cpu_req_t;

  typedef struct packed {
    logic op;
    logic explicit;
    logic [WAY_W-1:0] way;
    logic [ADDR_W-1:0] addr;
  } stl_maint_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } stl_mem_req_t;

  typedef struct packed {
    logic we;
    logic [WAY_W-1:0] way;
    logic [DBUF_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } stl_dbuf_t;

  localparam stl_tag_pins_t PINS_IDLE = '{index: '0, tag_bits: '0, hit_repl_sel: 1'b1,
    commit_n: 1'b1, write_n: 1'b1, flush_n: 1'b1, inval_n: 1'b1, pick_explicit: 1'b0,
    way_pick_bits: '0};

endpackage
`default_nettype wire

// File: hw/stl_timer.sv
/*
  small down-counter used to hold strobes and wait for tag settle.
  assumes load is a one-cycle pulse and len is at least one.
*/
`default_nettype none
module stl_timer (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [stl_pkg::TMR_W-1:0] len,
  // status
  output logic expired
);

  typedef struct packed {
    logic [stl_pkg::TMR_W-1:0] cnt;
  } stl_tmr_state_t;

  stl_tmr_state_t s_reg;
  stl_tmr_state_t s_next;

  // reload wins over counting so back-to-back waits never merge
  always_comb
  begin
    s_next = s_reg;
    if (load)
    begin
      s_next.cnt = len;
    end
    else if (s_reg.cnt != '0)
    begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign expired = (s_reg.cnt == '0);

endmodule
`default_nettype wire

// File: sim/stl_tag_model.sv
/*
  behavioural four-way tag buffer with a per-index usage table.
  assumes its pins come from flip-flops and stand through each strobe.
*/
`default_nettype none
module stl_tag_model (
  // pins from the controller
  input wire stl_pkg::stl_tag_pins_t pins,
  // answer to the controller
  output stl_pkg::stl_tag_resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] tag_mem [256][4];
  logic vld [256][4];
  logic [1:0] age [256][4];
  logic [7:0] gen = 8'h00;
  logic hit;
  logic [1:0] hit_way;
  logic [1:0] old_way;
  logic [1:0] sel;

  // compare every way; gen wakes this after table writes
  always @(pins, gen)
  begin
    hit = 1'b0;
    hit_way = 2'h0;
    old_way = 2'h0;
    for (int w = 0; w < 4; w++)
    begin
      if (vld[pins.index][w] === 1'b1 && tag_mem[pins.index][w] === pins.tag_bits)
      begin
        hit = 1'b1;
        hit_way = 2'(w);
      end
      if (age[pins.index][w] === 2'h3)
        old_way = 2'(w);
    end
    resp.match_n = ~hit;
    // a lookup that misses shows a junk way, the inverse of the oldest one
    resp.way_select_out = !pins.hit_repl_sel ? old_way : (hit ? hit_way : ~old_way);
  end

  // move one way to newest or oldest, shifting those between
  task automatic reorder(input logic [7:0] i, input logic [1:0] w, input logic fwd);
    logic [1:0] a;
    a = age[i][w];
    for (int k = 0; k < 4; k++)
      if (fwd && age[i][k] < a)
        age[i][k]++;
      else if (!fwd && age[i][k] > a)
        age[i][k]--;
    age[i][w] = fwd ? 2'h0 : 2'h3;
    gen++;
  endtask

  // purge empties all entries and restores the fixed order
  always @(negedge pins.flush_n)
  begin
    for (int i = 0; i < 256; i++)
      for (int w = 0; w < 4; w++)
      begin
        vld[i][w] = 1'b0;
        age[i][w] = 2'(w);
      end
    gen++;
  end

  // table changes other than purge land on the commit strobe, so inquiry leaves it alone
  always @(negedge pins.commit_n)
  begin
    #1;
    sel = pins.pick_explicit ? pins.way_pick_bits : hit_way;
    if (!pins.write_n)
    begin
      tag_mem[pins.index][resp.way_select_out] = pins.tag_bits;
      vld[pins.index][resp.way_select_out] = 1'b1;
      reorder(pins.index, resp.way_select_out, 1'b1);
    end
    else if (!pins.inval_n && (pins.pick_explicit || hit))
    begin
      vld[pins.index][sel] = 1'b0;
      reorder(pins.index, sel, 1'b0);
    end
    else if (pins.inval_n && hit)
      reorder(pins.index, hit_way, 1'b1);
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
/*
  self-checking bench: controller, tag model, data buffer and memory stubs.
  assumes stl_tag_model and a 40 mhz clock.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] T0 = 20'h1a2b3;
  logic clk, sys_rst, cpu_req, cpu_ack, maint_req, maint_done, mem_ack;
  stl_pkg::stl_cpu_req_t cpu_in;
  stl_pkg::stl_maint_t maint_in;
  stl_pkg::stl_tag_pins_t tag_pins;
  stl_pkg::stl_tag_resp_t tag_resp;
  stl_pkg::stl_dbuf_t dbuf;
  stl_pkg::stl_mem_req_t mem;
  logic [31:0] cpu_rdata, dbuf_rdata, mem_rdata;
  logic [31:0] dmem [4][1024];
  logic [31:0] mem_arr [logic [31:0]];
  int err_count = 0, compares = 0, rd_cnt = 0, wr_cnt = 0, mem_cnt = 0, mem_lat = 0, ack_rd = 0;

  stl_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_in(cpu_in), .cpu_ack(cpu_ack),
    .cpu_rdata(cpu_rdata), .maint_req(maint_req), .maint_in(maint_in), .maint_done(maint_done),
    .tag_pins(tag_pins), .tag_resp(tag_resp), .dbuf(dbuf), .dbuf_rdata(dbuf_rdata), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  stl_tag_model u_tag (.pins(tag_pins), .resp(tag_resp));

  function automatic logic [31:0] adr(input logic [19:0] t, input logic [7:0] i, input logic [1:0] wd);
    return {t, i, wd, 2'h0};
  endfunction
  function automatic logic [31:0] mget(input logic [31:0] a);
    return mem_arr.exists(a) ? mem_arr[a] : (a ^ 32'h5a5a0f0f);
  endfunction
  function automatic logic [11:0] snap();
    for (int w = 0; w < 4; w++)
      snap[w*3 +: 3] = {u_tag.vld[5][w], u_tag.age[5][w]};
  endfunction

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // data buffer stub: write on the pulse, read combinationally
  always @(posedge clk)
    if (dbuf.we === 1'b1)
      dmem[dbuf.way][dbuf.addr] <= dbuf.wdata;
  assign dbuf_rdata = dmem[dbuf.way][dbuf.addr];

  // memory stub: one word per ack after mem_lat cycles; data churns when idle
  always @(posedge clk)
  begin
    mem_rdata <= ~mem_rdata;
    if (mem_ack)
      mem_ack <= 1'b0;
    else if (mem.req === 1'b1 && mem_cnt < mem_lat)
      mem_cnt <= mem_cnt + 1;
    else if (mem.req === 1'b1)
    begin
      mem_ack <= 1'b1;
      mem_cnt <= 0;
      if (mem.we)
        mem_arr[mem.addr] = mem.wdata;
      else
        mem_rdata <= mget(mem.addr);
      if (mem.we)
        wr_cnt <= wr_cnt + 1;
      else
        rd_cnt <= rd_cnt + 1;
    end
  end

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait for a one-cycle answer, sampled mid-cycle
  task automatic wait_hi(input logic m);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((m ? maint_done : cpu_ack) !== 1'b1 && n < 300);
    if ((m ? maint_done : cpu_ack) !== 1'b1)
    begin
      chk(m ? "maint_done" : "cpu_ack", 64'h1, 64'h0);
      test_done();
    end
  endtask

  task automatic cpu_op(input logic we, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_in <= '{we: we, cacheable: 1'b1, addr: a, wdata: d};
    wait_hi(1'b0);
    ack_rd = rd_cnt;
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask

  task automatic maint_op(input logic op, input logic ex, input logic [1:0] w, input logic [31:0] a);
    @(posedge clk);
    maint_req <= 1'b1;
    maint_in <= '{op: op, explicit: ex, way: w, addr: a};
    wait_hi(1'b1);
    @(posedge clk);
    maint_req <= 1'b0;
  endtask

  // read and count line words fetched before the ack
  task automatic rd(input logic [31:0] a, input int n);
    int r0;
    r0 = rd_cnt;
    cpu_op(1'b0, a, 32'h0);
    chk("read data", 64'(mget(a)), 64'(cpu_rdata));
    chk("words before ack", 64'(n), 64'(ack_rd - r0));
  endtask

  task automatic t_reset();
    chk("idle pins", 64'(stl_pkg::PINS_IDLE), 64'(tag_pins));
    maint_op(stl_pkg::OP_FLUSH, 1'b0, 2'h0, 32'h0);
    chk("flush valid", 64'h0, 64'(u_tag.vld[9][0]));
    chk("flush order", 64'h2, 64'(u_tag.age[9][2]));
    $display("test reset done");
  endtask

  task automatic t_fill();
    for (int k = 0; k < 4; k++)
    begin
      mem_lat = k * 2;
      rd(adr(20'(T0 + k), 8'h05, 2'h1), 4);
      chk("refill way", 64'(T0 + k), 64'(u_tag.tag_mem[5][3 - k]));
    end
    rd(adr(T0, 8'h05, 2'h1), 0);
    rd(adr(T0 ^ 20'h80000, 8'h05, 2'h2), 4);
    chk("victim", 64'(T0 ^ 20'h80000), 64'(u_tag.tag_mem[5][2]));
    $display("test fill done");
  endtask

  task automatic t_write();
    int w0, r0;
    w0 = wr_cnt;
    cpu_op(1'b1, adr(T0, 8'h05, 2'h3), 32'hc0ffee01);
    chk("dbuf word", 64'h0c0ffee01, 64'(dmem[3][{8'h05, 2'h3}]));
    chk("memory writes", 64'h1, 64'(wr_cnt - w0));
    rd(adr(T0, 8'h05, 2'h3), 0);
    mem_lat = 3;
    r0 = rd_cnt;
    cpu_op(1'b1, adr(20'h0beef, 8'h09, 2'h2), 32'h600dcafe);
    chk("fill words", 64'h4, 64'(rd_cnt - r0));
    chk("line word", 64'(mget(adr(20'h0beef, 8'h09, 2'h0))), 64'(dmem[3][{8'h09, 2'h0}]));
    chk("new word", 64'h0600dcafe, 64'(dmem[3][{8'h09, 2'h2}]));
    chk("miss tag", 64'h0beef, 64'(u_tag.tag_mem[9][3]));
    $display("test write done");
  endtask

  task automatic t_uncached();
    logic [63:0] p0;
    p0 = 64'(tag_pins);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_in <= '{we: 1'b1, cacheable: 1'b0, addr: adr(T0, 8'h05, 2'h0), wdata: 32'h0};
    for (int n = 0; n < 20; n++)
    begin
      @(negedge clk);
      chk("bypass quiet", {p0[61:0], 2'h0}, 64'({tag_pins, cpu_ack, mem.req}));
    end
    @(posedge clk);
    cpu_req <= 1'b0;
    $display("test uncached done");
  endtask

  task automatic t_inval();
    logic [11:0] s;
    maint_op(stl_pkg::OP_INVAL, 1'b0, 2'h0, adr(T0, 8'h05, 2'h0));
    chk("inval valid", 64'h0, 64'(u_tag.vld[5][3]));
    chk("inval age", 64'h3, 64'(u_tag.age[5][3]));
    s = snap();
    maint_op(stl_pkg::OP_INVAL, 1'b0, 2'h0, adr(20'h77777, 8'h05, 2'h0));
    chk("no-match inval", 64'(s), 64'(snap()));
    maint_op(stl_pkg::OP_INVAL, 1'b1, 2'h1, adr(20'h77777, 8'h05, 2'h0));
    chk("pick valid", 64'h0, 64'(u_tag.vld[5][1]));
    rd(adr(20'(T0 + 5), 8'h05, 2'h0), 4);
    chk("refill picked", 64'(T0 + 5), 64'(u_tag.tag_mem[5][1]));
    $display("test inval done");
  endtask

  task automatic t_flush();
    maint_op(stl_pkg::OP_FLUSH, 1'b0, 2'h0, 32'h0);
    rd(adr(20'(T0 + 3), 8'h05, 2'h0), 4);
    chk("first victim", 64'(T0 + 3), 64'(u_tag.tag_mem[5][3]));
    $display("test flush done");
  endtask

  // reset for ten cycles, then the scenarios in turn
  initial
  begin
    sys_rst = 1'b1;
    cpu_req = 1'b0;
    cpu_in = '0;
    maint_req = 1'b0;
    maint_in = '0;
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_fill();
    t_write();
    t_uncached();
    t_inval();
    t_flush();
    test_done();
  end
endmodule
`default_nettype wire
